// file: rtl/rcr_map.svh
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

// apb register byte offsets
`define RCR_CMD_OFS       8'h00
`define RCR_STATUS_OFS    8'h04
`define RCR_FLAGS_OFS     8'h08
`define RCR_PROG_CNT_OFS  8'h0c
`define RCR_STACK_OFS     8'h10
`define RCR_MEM_ADDR_OFS  8'h14
`define RCR_MEM_DATA_OFS  8'h18

// flag byte bit positions
`define RCR_FLAG_C        3'h7
`define RCR_FLAG_Z        3'h6
`define RCR_FLAG_S        3'h5
`define RCR_FLAG_V        3'h4
`define RCR_FLAG_D        3'h3
`define RCR_FLAG_H        3'h2

// status bit positions
`define RCR_STAT_BUSY     1'h0
`define RCR_STAT_BAD      1'h1

// opcodes
`define RCR_OPC_CLR_CARRY 8'hcf
`define RCR_OPC_RETURN    8'haf
`define RCR_OPC_ROT_L     8'h90
`define RCR_OPC_ROT_L_IND 8'h91
`define RCR_OPC_ROT_LC    8'h10
`define RCR_OPC_ROT_LC_IND 8'h11
`define RCR_OPC_ROT_R     8'he0
`define RCR_OPC_ROT_R_IND 8'he1
`define RCR_OPC_ROT_RC    8'hc0
`define RCR_OPC_ROT_RC_IND 8'hc1

// cycle counts per instruction
`define RCR_CYC_CLR_CARRY 4'h4
`define RCR_CYC_RETURN    4'h8
`define RCR_CYC_ROTATE    4'h4

// reset values
`define RCR_FLAGS_RST     8'h00
`define RCR_PROG_CNT_RST  16'h0000
`define RCR_STACK_RST     8'h00

`endif

// file: rtl/rcr_pkg.sv
package rcr_pkg;
   // instruction kinds handled by the unit
   typedef enum logic [2:0] {
      none_op,
      clear_carry_op,
      return_op,
      rotate_left_op,
      rotate_left_thru_carry_op,
      rotate_right_op,
      rotate_right_thru_carry_op
   } op_e;
   // executor states
   typedef enum logic {st_idle, st_run} exec_state_e;
endpackage

// file: rtl/store_if.sv
`timescale 1ns/1ps
`default_nettype none
// single port to the register file and stack bytes
interface store_if;
   logic [7:0] addr;   // byte address
   logic [7:0] wdata;  // write data
   logic       we;     // write strobe
   logic [7:0] rdata;  // combinational read data
   modport owner (output addr, output wdata, output we, input rdata);
   modport mem   (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// file: rtl/byte_store.sv
`timescale 1ns/1ps
`default_nettype none
module byte_store
(
   // clock
   input  wire logic clk_in,
   // access port
   store_if.mem      bus
);
   // contents are data, not control, so no reset is spent on them
   logic [7:0] mem_r [256];

   // write on strobe
   always_ff @(posedge clk_in)
   begin
      if (bus.we)
      begin
         mem_r[bus.addr] <= bus.wdata;
      end
   end

   // asynchronous read keeps every instruction step to one cycle
   assign bus.rdata = mem_r[bus.addr];
endmodule // byte_store
`default_nettype wire

// file: rtl/rotate_alu.sv
`timescale 1ns/1ps
`default_nettype none
module rotate_alu
   import rcr_pkg::*;
(
   // operation and operand
   input  wire op_e        op_in,
   input  wire logic [7:0] value_in,
   input  wire logic       carry_in,
   // result and new flags
   output logic [7:0]      result_out,
   output logic            carry_out,
   output logic            zero_out,
   output logic            sign_out,
   output logic            ovf_out
);
   // rotation network
   always_comb
   begin
      result_out = value_in;
      carry_out  = carry_in;
      case (op_in)
         rotate_left_op:
         begin
            result_out = {value_in[6:0], value_in[7]};
            carry_out  = value_in[7];
         end
         rotate_left_thru_carry_op:
         begin
            result_out = {value_in[6:0], carry_in};
            carry_out  = value_in[7];
         end
         rotate_right_op:
         begin
            result_out = {value_in[0], value_in[7:1]};
            carry_out  = value_in[0];
         end
         rotate_right_thru_carry_op:
         begin
            result_out = {carry_in, value_in[7:1]};
            carry_out  = value_in[0];
         end
         default:
         begin
            result_out = value_in;
            carry_out  = carry_in;
         end
      endcase
   end

   // result flags
   assign zero_out = (result_out == 8'h00);
   assign sign_out = result_out[7];
   assign ovf_out  = result_out[7] ^ value_in[7];
endmodule // rotate_alu
`default_nettype wire

// file: rtl/rotate_carry_return_unit.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_map.svh"
module rotate_carry_return_unit
   import rcr_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // core state
   output logic             busy_out,
   output logic [7:0]       flags_out,
   output logic [15:0]      program_counter_out,
   output logic [7:0]       stack_pointer_out
);
   // opcode decode
   function automatic op_e decode_op(input logic [7:0] opc);
      case (opc)
         `RCR_OPC_CLR_CARRY:                      decode_op = clear_carry_op;
         `RCR_OPC_RETURN:                         decode_op = return_op;
         `RCR_OPC_ROT_L, `RCR_OPC_ROT_L_IND:      decode_op = rotate_left_op;
         `RCR_OPC_ROT_LC, `RCR_OPC_ROT_LC_IND:
            decode_op = rotate_left_thru_carry_op;
         `RCR_OPC_ROT_R, `RCR_OPC_ROT_R_IND:      decode_op = rotate_right_op;
         `RCR_OPC_ROT_RC, `RCR_OPC_ROT_RC_IND:
            decode_op = rotate_right_thru_carry_op;
         default:                                 decode_op = none_op;
      endcase
   endfunction

   // cycle count of an instruction
   function automatic logic [3:0] op_cycles(input op_e op);
      case (op)
         clear_carry_op: op_cycles = `RCR_CYC_CLR_CARRY;
         return_op:      op_cycles = `RCR_CYC_RETURN;
         default:        op_cycles = `RCR_CYC_ROTATE;
      endcase
   endfunction

   // true for the four rotations
   function automatic logic is_rotate(input op_e op);
      is_rotate = (op != none_op) && (op != clear_carry_op)
                  && (op != return_op);
   endfunction

   // bus handshake state
   logic        ack_r;             // access phase wait state done
   logic        err_r;             // refusal captured for this transfer
   logic [31:0] prdata_r;          // captured read data
   logic        access_w;          // access phase present
   logic        done_w;            // transfer completes this edge
   logic        wr_ok_w;           // write takes effect this edge
   logic        err_nxt;           // refusal of the pending transfer
   logic [31:0] rdata_nxt;         // read data of the pending transfer

   // executor state
   exec_state_e state_r;           // idle or running
   op_e         op_r;              // running instruction
   logic [7:0]  operand_r;         // operand byte
   logic        indirect_r;        // indirect_register_mode
   logic [7:0]  ptr_r;             // address fetched in indirect mode
   logic [3:0]  step_r;            // cycle within instruction
   logic [3:0]  last_r;            // final step
   logic        start_w;           // a legal command is accepted
   logic        final_w;           // last cycle of the instruction
   logic        rot_wr_w;          // rotation writes back this cycle

   // architectural state
   logic [7:0]  flags_r;
   logic [15:0] program_counter_r;
   logic [7:0]  stack_pointer_r;
   logic [7:0]  mem_addr_r;        // software window into the store
   logic        bad_cmd_r;         // sticky unknown opcode

   // rotation results
   logic [7:0]  rot_result_w;
   logic        rot_carry_w;
   logic        rot_zero_w;
   logic        rot_sign_w;
   logic        rot_ovf_w;

   store_if store_bus ();

   // storage and rotation network
   byte_store u_store
   (
      .clk_in (clk_in),
      .bus    (store_bus.mem)
   );

   rotate_alu u_alu
   (
      .op_in      (op_r),
      .value_in   (store_bus.rdata),
      .carry_in   (flags_r[`RCR_FLAG_C]),
      .result_out (rot_result_w),
      .carry_out  (rot_carry_w),
      .zero_out   (rot_zero_w),
      .sign_out   (rot_sign_w),
      .ovf_out    (rot_ovf_w)
   );

   assign access_w = psel_in && penable_in;
   assign done_w   = access_w && ack_r;
   assign wr_ok_w  = done_w && pwrite_in && !err_r;
   assign start_w  = wr_ok_w && (paddr_in == `RCR_CMD_OFS)
                     && (decode_op(pwdata_in[7:0]) != none_op);
   assign final_w  = (state_r == st_run) && (step_r == last_r);
   assign rot_wr_w = (state_r == st_run) && is_rotate(op_r)
                     && (step_r == 4'h1);

   // refusal and read mux; the store port belongs to the executor when busy
   always_comb
   begin
      err_nxt   = 1'b0;
      rdata_nxt = 32'h0000_0000;
      case (paddr_in)
         `RCR_CMD_OFS:      err_nxt = pwrite_in && (state_r == st_run);
         `RCR_STATUS_OFS:
            rdata_nxt = {30'h0, bad_cmd_r, (state_r == st_run)};
         `RCR_FLAGS_OFS:
         begin
            err_nxt   = pwrite_in && (state_r == st_run);
            rdata_nxt = {24'h0, flags_r};
         end
         `RCR_PROG_CNT_OFS:
         begin
            err_nxt   = pwrite_in && (state_r == st_run);
            rdata_nxt = {16'h0, program_counter_r};
         end
         `RCR_STACK_OFS:
         begin
            err_nxt   = pwrite_in && (state_r == st_run);
            rdata_nxt = {24'h0, stack_pointer_r};
         end
         `RCR_MEM_ADDR_OFS: rdata_nxt = {24'h0, mem_addr_r};
         `RCR_MEM_DATA_OFS:
         begin
            err_nxt   = (state_r == st_run);
            rdata_nxt = (state_r == st_run) ? 32'h0 : {24'h0, store_bus.rdata};
         end
         default:           err_nxt = 1'b1;
      endcase
   end

   // one wait state so read data can come from a flop
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ack_r    <= 1'b0;
         err_r    <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else if (access_w && !ack_r)
      begin
         ack_r    <= 1'b1;
         err_r    <= err_nxt;
         prdata_r <= rdata_nxt;
      end
      else
      begin
         ack_r <= 1'b0;
      end
   end

   assign pready_out  = ack_r;
   assign pslverr_out = ack_r && err_r;
   assign prdata_out  = prdata_r;

   // store port: executor when running, software window when idle
   always_comb
   begin
      store_bus.addr  = mem_addr_r;
      store_bus.wdata = pwdata_in[7:0];
      store_bus.we    = wr_ok_w && (paddr_in == `RCR_MEM_DATA_OFS);
      if (state_r == st_run)
      begin
         store_bus.wdata = rot_result_w;
         store_bus.we    = rot_wr_w;
         if (op_r == return_op)
         begin
            // first byte at the pointer, second one above it
            store_bus.addr = (step_r == 4'h0) ? stack_pointer_r
                             : 8'(stack_pointer_r + 8'h01);
         end
         else if (step_r == 4'h1 && indirect_r)
         begin
            store_bus.addr = ptr_r;
         end
         else
         begin
            store_bus.addr = operand_r;
         end
      end
   end

   // instruction sequencing
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_r    <= st_idle;
         op_r       <= none_op;
         operand_r  <= 8'h00;
         indirect_r <= 1'b0;
         step_r     <= 4'h0;
         last_r     <= 4'h0;
      end
      else
      begin
         case (state_r)
            st_idle:
            begin
               if (start_w)
               begin
                  state_r    <= st_run;
                  op_r       <= decode_op(pwdata_in[7:0]);
                  operand_r  <= pwdata_in[15:8];
                  indirect_r <= pwdata_in[0];
                  step_r     <= 4'h0;
                  last_r     <= 4'(op_cycles(decode_op(pwdata_in[7:0]))
                                   - 4'h1);
               end
            end
            st_run:
            begin
               step_r <= 4'(step_r + 4'h1);
               if (final_w)
               begin
                  state_r <= st_idle;
               end
            end
            default: state_r <= st_idle;
         endcase
      end
   end

   // indirect pointer fetch; the pointer register is only read
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ptr_r <= 8'h00;
      end
      else if (state_r == st_run && is_rotate(op_r) && step_r == 4'h0)
      begin
         ptr_r <= store_bus.rdata;
      end
   end

   // flags: software write when idle, instruction effects when running
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         flags_r <= `RCR_FLAGS_RST;
      end
      else if (wr_ok_w && paddr_in == `RCR_FLAGS_OFS)
      begin
         flags_r <= pwdata_in[7:0];
      end
      else if (state_r == st_run && op_r == clear_carry_op
               && step_r == 4'h0)
      begin
         flags_r[`RCR_FLAG_C] <= 1'b0;
      end
      else if (rot_wr_w)
      begin
         // d and h are left alone
         flags_r[`RCR_FLAG_C] <= rot_carry_w;
         flags_r[`RCR_FLAG_Z] <= rot_zero_w;
         flags_r[`RCR_FLAG_S] <= rot_sign_w;
         flags_r[`RCR_FLAG_V] <= rot_ovf_w;
      end
   end

   // program counter: popped on return, else stepped past the instruction
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         program_counter_r <= `RCR_PROG_CNT_RST;
      end
      else if (wr_ok_w && paddr_in == `RCR_PROG_CNT_OFS)
      begin
         program_counter_r <= pwdata_in[15:0];
      end
      else if (state_r == st_run && op_r == return_op)
      begin
         if (step_r == 4'h0)
         begin
            program_counter_r[15:8] <= store_bus.rdata;
         end
         else if (step_r == 4'h1)
         begin
            program_counter_r[7:0] <= store_bus.rdata;
         end
      end
      else if (final_w)
      begin
         // one byte for clear carry, two for a rotation
         program_counter_r <= 16'(program_counter_r
                              + (is_rotate(op_r) ? 16'h0002 : 16'h0001));
      end
   end

   // stack pointer: software write or return adjust after both pops
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         stack_pointer_r <= `RCR_STACK_RST;
      end
      else if (wr_ok_w && paddr_in == `RCR_STACK_OFS)
      begin
         stack_pointer_r <= pwdata_in[7:0];
      end
      else if (state_r == st_run && op_r == return_op && step_r == 4'h2)
      begin
         stack_pointer_r <= 8'(stack_pointer_r + 8'h02);
      end
   end

   // software window address and sticky bad opcode; set beats clear
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         mem_addr_r <= 8'h00;
         bad_cmd_r  <= 1'b0;
      end
      else
      begin
         if (wr_ok_w && paddr_in == `RCR_MEM_ADDR_OFS)
         begin
            mem_addr_r <= pwdata_in[7:0];
         end
         if (wr_ok_w && paddr_in == `RCR_CMD_OFS && !start_w)
         begin
            bad_cmd_r <= 1'b1;
         end
         else if (wr_ok_w && paddr_in == `RCR_STATUS_OFS
                  && pwdata_in[`RCR_STAT_BAD])
         begin
            bad_cmd_r <= 1'b0;
         end
      end
   end

   assign busy_out            = (state_r == st_run);
   assign flags_out           = flags_r;
   assign program_counter_out = program_counter_r;
   assign stack_pointer_out   = stack_pointer_r;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   chk_clear_carry_only: assert property
      ((state_r == st_run && op_r == clear_carry_op && step_r == 4'h0)
       |=> !flags_r[`RCR_FLAG_C] && flags_r[6:0] == $past(flags_r[6:0]))
      else $error("clear carry wrong");
   chk_return_cycles: assert property
      ((start_w && decode_op(pwdata_in[7:0]) == return_op)
       |=> busy_out [*8] ##1 !busy_out)
      else $error("return not eight cycles");
   chk_return_stack_add: assert property
      ((start_w && decode_op(pwdata_in[7:0]) == return_op)
       |-> ##9 stack_pointer_r == 8'($past(stack_pointer_r, 9) + 8'h02))
      else $error("return stack adjust wrong");
   chk_return_byte_order: assert property
      ((state_r == st_run && op_r == return_op && step_r == 4'h1)
       |=> program_counter_r == {$past(program_counter_r[15:8]),
                                 $past(store_bus.rdata)}
           && $past(store_bus.addr) == 8'($past(stack_pointer_r) + 8'h01))
      else $error("return byte order wrong");
   chk_rotate_left_val: assert property
      ((rot_wr_w && op_r == rotate_left_op) |->
       store_bus.wdata == {store_bus.rdata[6:0], store_bus.rdata[7]}
       ##1 flags_r[`RCR_FLAG_C] == $past(store_bus.rdata[7]))
      else $error("rotate left wrong");
   chk_rotate_lc_val: assert property
      ((rot_wr_w && op_r == rotate_left_thru_carry_op) |->
       store_bus.wdata == {store_bus.rdata[6:0], flags_r[`RCR_FLAG_C]})
      else $error("rotate left via carry wrong");
   chk_rotate_right_val: assert property
      ((rot_wr_w && op_r == rotate_right_op) |->
       store_bus.wdata == {store_bus.rdata[0], store_bus.rdata[7:1]})
      else $error("rotate right wrong");
   chk_rotate_rc_val: assert property
      ((rot_wr_w && op_r == rotate_right_thru_carry_op) |->
       store_bus.wdata == {flags_r[`RCR_FLAG_C], store_bus.rdata[7:1]}
       ##1 flags_r[`RCR_FLAG_C] == $past(store_bus.rdata[0]))
      else $error("rotate right via carry wrong");
   chk_zero_sign_flags: assert property
      (rot_wr_w |=> flags_r[`RCR_FLAG_Z] == ($past(store_bus.wdata) == 8'h00)
       && flags_r[`RCR_FLAG_S] == $past(store_bus.wdata[7]))
      else $error("zero or sign flag wrong");
   chk_ovf_keep_dh: assert property
      (rot_wr_w |=> flags_r[`RCR_FLAG_V] ==
       ($past(store_bus.wdata[7]) ^ $past(store_bus.rdata[7]))
       && flags_r[3:0] == $past(flags_r[3:0]))
      else $error("overflow or d h wrong");
   chk_indirect_target: assert property
      ((rot_wr_w && indirect_r) |-> store_bus.addr == ptr_r
       && $past(store_bus.addr) == operand_r)
      else $error("indirect target wrong");
   chk_rotate_cycles: assert property
      ((start_w && is_rotate(decode_op(pwdata_in[7:0])))
       |=> busy_out [*4] ##1 !busy_out)
      else $error("rotate not four cycles");

   cov_return_run: cover property (final_w && op_r == return_op);
   cov_indirect_rot: cover property (rot_wr_w && indirect_r);
   cov_clear_carry: cover property (final_w && op_r == clear_carry_op);
   cov_refused_cmd: cover property (pslverr_out && busy_out);
endmodule // rotate_carry_return_unit
`default_nettype wire

// file: test/store_ref.sv
`timescale 1ns/1ps
`default_nettype none
// mirror of the register file and stack bytes as software and the reference rotations left them;
// the bench reads its store expectations from here; the return test takes its flags expectation from the design
module store_ref;
   logic [7:0] m [0:255];  // byte image
endmodule // store_ref
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcr_map.svh"
module tb_top;
   // design inputs
   logic        clk_in = 0, rstn_in = 0;
   logic        psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic [7:0]  paddr_in = 0;
   logic [31:0] pwdata_in = 0;
   // design outputs
   logic [31:0] prdata_out;
   logic        pready_out, pslverr_out, busy_out;
   logic [7:0]  flags_out, stack_pointer_out;
   logic [15:0] program_counter_out;
   int          n_fail = 0, checked = 0, nb = 0;
   logic [31:0] seed = 69;  // xorshift state
   logic [31:0] x;
   logic [7:0]  ops [8] = '{8'h90, 8'h91, 8'h10, 8'h11,
                            8'he0, 8'he1, 8'hc0, 8'hc1};
   store_ref REF ();
   rotate_carry_return_unit DUT (.clk_in(clk_in), .rstn_in(rstn_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out),
      .busy_out(busy_out), .flags_out(flags_out),
      .program_counter_out(program_counter_out),
      .stack_pointer_out(stack_pointer_out));
   // 50 ns clock
   initial
   begin
      forever #25 clk_in = ~clk_in;
   end
   // busy length, cleared by the bench before each command
   always @(posedge clk_in) if (busy_out === 1'b1) nb++;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one apb transfer; ready, data and refusal all taken at one rising
   // edge, request held until then; only the watchdog ends a long wait
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      @(posedge clk_in);
      psel_in <= 1; penable_in <= 0; pwrite_in <= w;
      paddr_in <= a; pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1;
      do
         @(posedge clk_in);
      while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 0; penable_in <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1, a, d, r, e);
   endtask
   task automatic rdv(input logic [7:0] a, output logic [31:0] v);
      logic e;
      apb(0, a, 0, v, e);
   endtask
   // store byte written through the window, mirrored in the model
   task automatic mw(input logic [7:0] a, input logic [7:0] d);
      wr(`RCR_MEM_ADDR_OFS, {24'h0, a});
      wr(`RCR_MEM_DATA_OFS, {24'h0, d});
      REF.m[a] = d;
   endtask
   task automatic mr(input logic [7:0] a, output logic [31:0] v);
      wr(`RCR_MEM_ADDR_OFS, {24'h0, a});
      rdv(`RCR_MEM_DATA_OFS, v);
   endtask
   // issue a command, try a second one while busy, poll until done
   task automatic exec(input logic [15:0] cmd, input int cyc);
      logic [31:0] r;
      logic e;
      nb = 0;
      wr(`RCR_CMD_OFS, {16'h0, cmd});
      apb(1, `RCR_CMD_OFS, {16'h0, cmd}, r, e);
      chk(e, 1);
      r = 1;
      while (r[0] !== 1'b0)
      begin
         rdv(`RCR_STATUS_OFS, r);
      end
      chk(nb, cyc);
   endtask
   task automatic end_sim();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // hang guard, far beyond the expected run
   initial
   begin
      #1000000;
      n_fail++;
      end_sim();
   end
   initial
   begin : main
      logic [7:0]  op, v, p, t, f, r, ef, sp;
      logic [15:0] pc;
      logic        c;
      logic [31:0] rv;
      logic        e;
      repeat (4) @(posedge clk_in);
      rstn_in <= 1;
      chk(flags_out, 0);
      pc = rnd();
      wr(`RCR_PROG_CNT_OFS, {16'h0, pc});
      // every rotate opcode twice, the first pass from a zero operand
      for (int i = 0; i < 16; i++)
      begin
         x = rnd();
         op = ops[i % 8];
         v = (i < 8) ? 8'h00 : x[7:0];
         f = x[15:8];
         p = x[23:16];
         t = op[0] ? (p ^ (x[31:24] | 8'h01)) : p;
         if (op[0]) mw(p, t);
         mw(t, v);
         wr(`RCR_FLAGS_OFS, {24'h0, f});
         exec({p, op}, 4);
         // reference rotation on the model's copy of the target
         v = REF.m[t];
         case (op[7:4])
            4'h9: begin r = {v[6:0], v[7]}; c = v[7]; end
            4'h1: begin r = {v[6:0], f[7]}; c = v[7]; end
            4'he: begin r = {v[0], v[7:1]}; c = v[0]; end
            default: begin r = {f[7], v[7:1]}; c = v[0]; end
         endcase
         ef = {c, r == 8'h00, r[7], r[7] ^ v[7], f[3:0]};
         REF.m[t] = r;
         mr(t, rv);
         chk(rv, {24'h0, REF.m[t]});
         chk(flags_out, ef);
         rdv(`RCR_FLAGS_OFS, rv);
         chk(rv, {24'h0, ef});
         pc = pc + 16'd2;
         chk(program_counter_out, pc);
         if (op[0]) mr(p, rv);
         if (op[0]) chk(rv, {24'h0, REF.m[p]});
      end
      // clear carry from a set carry, other flags random
      for (int i = 0; i < 2; i++)
      begin
         f = rnd() | 8'h80;
         wr(`RCR_FLAGS_OFS, {24'h0, f});
         exec({8'h00, 8'hcf}, 4);
         chk(flags_out, f & 8'h7f);
         pc = pc + 16'd1;
         chk(program_counter_out, pc);
      end
      // return, including the top of the stack wrapping
      for (int i = 0; i < 3; i++)
      begin
         x = rnd();
         sp = (i == 0) ? 8'hff : x[7:0];
         mw(sp, x[15:8]);
         mw(sp + 8'd1, x[23:16]);
         wr(`RCR_STACK_OFS, {24'h0, sp});
         f = flags_out;
         exec({8'h00, 8'haf}, 8);
         pc = {REF.m[sp], REF.m[8'(sp + 8'd1)]};
         chk(program_counter_out, pc);
         chk(stack_pointer_out, 8'(sp + 8'd2));
         chk(flags_out, f);
         rdv(`RCR_PROG_CNT_OFS, rv);
         chk(rv, {16'h0, pc});
         rdv(`RCR_STACK_OFS, rv);
         chk(rv, {24'h0, 8'(sp + 8'd2)});
      end
      // unknown opcode sets the sticky status bit, writing one clears it
      wr(`RCR_CMD_OFS, 32'h0000_0000);
      rdv(`RCR_STATUS_OFS, rv);
      chk(rv, 32'h0000_0002);
      wr(`RCR_STATUS_OFS, 32'h0000_0002);
      rdv(`RCR_STATUS_OFS, rv);
      chk(rv, 32'h0000_0000);
      // unmapped address is refused and reads zero
      apb(0, 8'h40, 0, rv, e);
      chk(e, 1);
      chk(rv, 0);
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
